// ==== rgbt_core.v ====
/*
  rgbt_core: timing and current-setting core of a three-channel led sink
  driver, with its i2c-compatible register slave.
  assumes scl and sda arrive from pins (asynchronous to clock), an
  external open-drain buffer resolves sda from sda_out/sda_oe, and the
  analog sinks consume the per-channel step count on sink_output_*.
*/
// Function
// - each channel has its own 8-bit current register setting its level.
// - each channel takes one of 192 current levels or is off.
// - outside ramps the channel current is steady, no pulsing.
// - ramps use pwm whose duty rises for ramp-up, falls for ramp-down.
// - ramp time register holds 4-bit rise and 4-bit fall fields.
// - flash period bit 7 selects linear (1) or s-curve (0) ramp.
// - after reset the ramp profile is the s-curve.
// - ramp-up goes zero to full current, ramp-down back to zero.
// - 7-bit flash period, 64 ms plus 256 ms per step.
// - one flash period counter serves all three channels.
// - two on-time registers give on time as fraction of period.
// - on-time duty has 256 steps from 0 to 99.6 percent.
// - on time includes the rise ramp and the full-on part.
// - each channel may follow on-time timer one or timer two.
// - each channel follows a timer, or is forced off, or forced on.
// - slot select places the second waveform within the period.
// - second waveform past period end is cut and timers restart.
// - current built from 48 units of 0.5 ma, 0.125 ma effective steps.
// - channel assignment register at zero turns all outputs off.
// - control bits 1:0 pick slots 1-4; bit 2 set with bits 1:0 nonzero means reset command.
`timescale 1ns/1ns
`include "rgbt_regs.vh"

module rgbt_core #(
  parameter [6:0]  DEV_ADDR         = 7'h30,
  parameter [13:0] BASE_TICK_CYCLES = `RGBT_BASE_TICK_CYCLES
) (
  // clock and reset
  input  wire       clock,
  input  wire       reset,
  // i2c pins
  input  wire       scl_pin,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  // sink drive: number of 0.125 ma steps, zero when off
  output wire [7:0] sink_output_one,
  output wire [7:0] sink_output_two,
  output wire [7:0] sink_output_three
);

  // i2c slave states
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_ADDR = 6'h02;
  localparam [5:0] S_ACK  = 6'h04;
  localparam [5:0] S_WR   = 6'h08;
  localparam [5:0] S_RD   = 6'h10;
  localparam [5:0] S_RACK = 6'h20;

  reg  [7:0]  regs [0:8];
  reg  [7:0]  lvl [0:2];
  reg  [7:0]  drive [0:2];
  reg         scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  reg  [5:0]  state;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  shift;
  reg  [7:0]  ptr;
  reg         got_ptr;
  reg         is_read;
  reg  [13:0] base_cnt;
  reg         base_tick;
  reg  [9:0]  mult_cnt;
  reg  [7:0]  phase;
  reg  [3:0]  ramp_div;
  reg  [7:0]  pwm_cnt;
  reg  [9:0]  start2;
  reg  [2:0]  want;
  reg  [1:0]  sel;
  wire        scl_rise, scl_fall, bus_start, bus_stop;
  wire [7:0]  rd_val;
  wire [9:0]  period_steps;
  wire        win1, win2, ramp_tick;
  integer     i, wi, ci;

  // defaults restored by reset and by the register reset commands
  function [7:0] def_val;
    input [3:0] idx;
    begin
      case (idx)
        `RGBT_OFS_CONTROL:        def_val = `RGBT_RST_CONTROL;
        `RGBT_OFS_FLASH_PERIOD:   def_val = `RGBT_RST_FLASH_PERIOD;
        `RGBT_OFS_ON_TIME_ONE:    def_val = `RGBT_RST_ON_TIME_ONE;
        `RGBT_OFS_ON_TIME_TWO:    def_val = `RGBT_RST_ON_TIME_TWO;
        `RGBT_OFS_CHANNEL_ASSIGN: def_val = `RGBT_RST_CHANNEL_ASSIGN;
        `RGBT_OFS_RAMP_TIMES:     def_val = `RGBT_RST_RAMP_TIMES;
        `RGBT_OFS_CURRENT_ONE:    def_val = `RGBT_RST_CURRENT_ONE;
        default:                  def_val = `RGBT_RST_CURRENT_OTHER;
      endcase
    end
  endfunction

  // ramp step per ramp tick; code zero means an instant edge
  function [7:0] ramp_step;
    input [3:0] code;
    begin
      ramp_step = (code == 4'h0) ? 8'hff : {4'h0, 4'hf - code} + 8'h01;
    end
  endfunction

  // ramp profile: linear, or a quadratic s-curve symmetric at midpoint
  function [7:0] shape;
    input [7:0] x;
    input       linear;
    reg   [15:0] sq;
    reg   [7:0]  m;
    begin
      m  = x[7] ? 8'hff - x : x;
      sq = m * m;
      if (linear)
        shape = x;
      else if (x[7])
        shape = 8'hff - sq[14:7];
      else
        shape = sq[14:7];
    end
  endfunction

  // current code to 0.125 ma steps: 48 units of 0.5 ma, 4 fine steps
  function [7:0] quarter;
    input [7:0] code;
    begin
      if (code > `RGBT_MAX_CURRENT_CODE)
        quarter = `RGBT_MAX_CURRENT_CODE + 8'h01;
      else
        quarter = code + 8'h01;
    end
  endfunction

  // pin synchronisers: second stage and its delayed copy feed logic
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_pin;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
  assign rd_val    = (ptr <= {4'h0, `RGBT_OFS_LAST}) ? regs[ptr[3:0]]
                                                    : 8'h00;

  // i2c slave and register file; sda only ever pulled low
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state   <= S_IDLE;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
      ptr     <= 8'h00;
      got_ptr <= 1'b0;
      is_read <= 1'b0;
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
      for (i = 0; i < 9; i = i + 1)
        regs[i] <= def_val(i[3:0]);
    end else if (bus_start) begin
      state   <= S_ADDR;
      bit_cnt <= 4'h0;
      got_ptr <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (bus_stop) begin
      state  <= S_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        S_ADDR, S_WR: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            state  <= S_ACK;
            sda_oe <= 1'b1;
            if (state == S_ADDR) begin
              is_read <= shift[0];
              if (shift[7:1] != DEV_ADDR) begin
                state  <= S_IDLE;
                sda_oe <= 1'b0;
              end
            end else if (!got_ptr) begin
              ptr     <= shift;
              got_ptr <= 1'b1;
            end else begin
              ptr <= ptr + 8'h01;
              if (ptr == {4'h0, `RGBT_OFS_CONTROL}) begin
                if (shift[`RGBT_CMD_BIT] &&
                    shift[1:0] != `RGBT_CMD_NOP) begin
                  for (i = 0; i < 9; i = i + 1)
                    regs[i] <= def_val(i[3:0]);
                end else begin
                  regs[0] <= {shift[7:3], 1'b0, shift[1:0]};
                end
              end else if (ptr <= {4'h0, `RGBT_OFS_LAST}) begin
                regs[ptr[3:0]] <= shift;
              end
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            sda_oe  <= 1'b0;
            bit_cnt <= 4'h0;
            state   <= S_WR;
            if (is_read) begin
              state   <= S_RD;
              sda_oe  <= ~rd_val[7];
              shift   <= {rd_val[6:0], 1'b0};
              bit_cnt <= 4'h1;
              ptr     <= ptr + 8'h01;
            end
          end
        end
        S_RD: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_oe <= 1'b0;
              state  <= S_RACK;
            end else begin
              sda_oe  <= ~shift[7];
              shift   <= {shift[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        S_RACK: begin
          // master nack ends the read; ack reloads at the next fall
          if (scl_rise)
            state <= sda_s ? S_IDLE : S_ACK;
        end
        default: begin
          state  <= S_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // period step = 0.25 ms * (1 + 4n), 256 steps per period
  assign period_steps = {3'h0, regs[`RGBT_OFS_FLASH_PERIOD][6:0]} *
                        `RGBT_MS_PER_PERIOD_STEP + 10'h001;
  assign ramp_tick    = base_tick && ramp_div == `RGBT_RAMP_DIV_LAST;

  // one base tick drives period, on-time and ramp timing
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      base_cnt  <= 14'h0000;
      base_tick <= 1'b0;
      mult_cnt  <= 10'h000;
      phase     <= 8'h00;
      ramp_div  <= 4'h0;
      pwm_cnt   <= 8'h00;
    end else begin
      pwm_cnt   <= pwm_cnt + 8'h01;
      base_tick <= (base_cnt == BASE_TICK_CYCLES - 14'h0001);
      base_cnt  <= (base_cnt == BASE_TICK_CYCLES - 14'h0001)
                   ? 14'h0000 : base_cnt + 14'h0001;
      if (base_tick) begin
        ramp_div <= ramp_div + 4'h1;
        if (mult_cnt >= period_steps - 10'h001) begin
          mult_cnt <= 10'h000;
          phase    <= phase + 8'h01;
        end else begin
          mult_cnt <= mult_cnt + 10'h001;
        end
      end
    end
  end

  always @* begin
    case (regs[`RGBT_OFS_CONTROL][1:0])
      2'h0:    start2 = 10'h000;
      2'h1:    start2 = {2'h0, regs[`RGBT_OFS_ON_TIME_ONE]};
      2'h2:    start2 = `RGBT_HALF_PERIOD;
      default: start2 = {1'b0, regs[`RGBT_OFS_ON_TIME_ONE], 1'b0};
    endcase
  end

  // two on-time windows; 256 phase steps each
  assign win1 = phase < regs[`RGBT_OFS_ON_TIME_ONE];
  // window past phase 255 is cut when the phase wraps
  assign win2 = {2'h0, phase} >= start2 &&
                {2'h0, phase} < start2 +
                                {2'h0, regs[`RGBT_OFS_ON_TIME_TWO]};

  // per-channel source: off, on, timer one, timer two
  always @* begin
    sel  = 2'h0;
    want = 3'h0;
    for (wi = 0; wi < 3; wi = wi + 1) begin
      sel = regs[`RGBT_OFS_CHANNEL_ASSIGN][2*wi +: 2];
      case (sel)
        `RGBT_ASSIGN_ON:        want[wi] = 1'b1;
        `RGBT_ASSIGN_TIMER_ONE: want[wi] = win1;
        `RGBT_ASSIGN_TIMER_TWO: want[wi] = win2;
        default:                want[wi] = 1'b0;
      endcase
    end
  end

  // ramp level and sink drive per channel
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      for (ci = 0; ci < 3; ci = ci + 1) begin
        lvl[ci]   <= 8'h00;
        drive[ci] <= 8'h00;
      end
    end else begin
      for (ci = 0; ci < 3; ci = ci + 1) begin
        // rise starts with the window, part of the on time
        if (want[ci] && (ramp_tick ||
            regs[`RGBT_OFS_RAMP_TIMES][3:0] == 4'h0)) begin
          if (lvl[ci] > 8'hff - ramp_step(regs[`RGBT_OFS_RAMP_TIMES][3:0]))
            lvl[ci] <= 8'hff;
          else
            lvl[ci] <= lvl[ci] + ramp_step(regs[`RGBT_OFS_RAMP_TIMES][3:0]);
        end else if (!want[ci] && (ramp_tick ||
                     regs[`RGBT_OFS_RAMP_TIMES][7:4] == 4'h0)) begin
          // fall field sets the down step
          if (lvl[ci] < ramp_step(regs[`RGBT_OFS_RAMP_TIMES][7:4]))
            lvl[ci] <= 8'h00;
          else
            lvl[ci] <= lvl[ci] - ramp_step(regs[`RGBT_OFS_RAMP_TIMES][7:4]);
        end
        // full and zero levels bypass the pwm, no pulsing
        if (lvl[ci] == 8'h00)
          drive[ci] <= 8'h00;
        else if (lvl[ci] == 8'hff)
          // channel current register alone sets level
          drive[ci] <= quarter(regs[`RGBT_OFS_CURRENT_ONE + ci]);
        // pwm duty follows the shaped ramp level
        else if (pwm_cnt < shape(lvl[ci],
                 regs[`RGBT_OFS_FLASH_PERIOD][`RGBT_LINEAR_BIT]))
          // profile selected above; 0.125 ma steps
          drive[ci] <= quarter(regs[`RGBT_OFS_CURRENT_ONE + ci]);
        else
          drive[ci] <= 8'h00;
      end
    end
  end

  // off or one of 192 levels; assignment zero keeps all off
  assign sink_output_one   = drive[0];
  assign sink_output_two   = drive[1];
  assign sink_output_three = drive[2];

endmodule

// ==== rgbt_regs.vh ====
/*
  register offsets, reset values, field positions and timing constants
  of the rgb flash/ramp timer core; included by rgbt_core.v only.
*/
`ifndef RGBT_REGS_VH
`define RGBT_REGS_VH

// register offsets
`define RGBT_OFS_CONTROL        4'h0
`define RGBT_OFS_FLASH_PERIOD   4'h1
`define RGBT_OFS_ON_TIME_ONE    4'h2
`define RGBT_OFS_ON_TIME_TWO    4'h3
`define RGBT_OFS_CHANNEL_ASSIGN 4'h4
`define RGBT_OFS_RAMP_TIMES     4'h5
`define RGBT_OFS_CURRENT_ONE    4'h6
`define RGBT_OFS_LAST           4'h8

// reset values
`define RGBT_RST_CONTROL        8'h00
`define RGBT_RST_FLASH_PERIOD   8'h00
`define RGBT_RST_ON_TIME_ONE    8'h81
`define RGBT_RST_ON_TIME_TWO    8'h01
`define RGBT_RST_CHANNEL_ASSIGN 8'h82
`define RGBT_RST_RAMP_TIMES     8'h00
`define RGBT_RST_CURRENT_ONE    8'h3f
`define RGBT_RST_CURRENT_OTHER  8'h9f

// field positions
`define RGBT_LINEAR_BIT         7
`define RGBT_CMD_BIT            2
`define RGBT_CMD_NOP            2'h0

// channel assignment codes, two bits per channel
`define RGBT_ASSIGN_OFF         2'h0
`define RGBT_ASSIGN_ON          2'h1
`define RGBT_ASSIGN_TIMER_ONE   2'h2
`define RGBT_ASSIGN_TIMER_TWO   2'h3

// current code limits: 192 levels of 0.125 ma
`define RGBT_MAX_CURRENT_CODE   8'hbf

// timing: flash period step = (64 ms + 256 ms * n) / 256
`define RGBT_CLK_PERIOD_NS      20
`define RGBT_BASE_TICK_US       250
// 0.25 ms base tick at a 20 ns clock
`define RGBT_BASE_TICK_CYCLES   14'd12500
`define RGBT_MS_PER_PERIOD_STEP 10'h004
`define RGBT_RAMP_DIV_LAST      4'hf
`define RGBT_HALF_PERIOD        10'h080

`endif

// ==== rgbt_host_model.sv ====
/*
  i2c host model driving the led timer core's register port.
  assumes one open-drain sda wire with a pull-up; scl idles high.
*/
`timescale 1ns/1ns
module rgbt_host_model (
  // bus pins
  output logic scl_pin,
  output wire  sda_in,
  input  wire  sda_oe
);
  logic       host_low;
  logic       ack;
  int         nacks;
  logic [7:0] rx [0:15];
  // wired-and level, pulled up once both sides let go
  assign sda_in = !(host_low | sda_oe);
  // bus idle at time zero
  initial begin
    scl_pin = 1'b1;
    host_low = 1'b0;
    nacks = 0;
  end
  // start or repeated start, leaves scl low
  task automatic start_bit();
    host_low = 1'b0;
    #40 scl_pin = 1'b1;
    #80 host_low = 1'b1;
    #80 scl_pin = 1'b0;
    #40;
  endtask
  task automatic stop_bit();
    host_low = 1'b1;
    #40 scl_pin = 1'b1;
    #80 host_low = 1'b0;
    #80;
  endtask
  // data moves only in scl low, sampled at the end of scl high
  task automatic bit_io(input logic b, output logic r);
    host_low = !b;
    #40 scl_pin = 1'b1;
    #80 r = sda_in;
    scl_pin = 1'b0;
    #40;
  endtask
  // one byte msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic m,
                      output logic [7:0] q);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(m, ack);
  endtask
  // host byte; a missing acknowledge is counted
  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    xfer(d, 1'b1, q);
    nacks += ack;
  endtask
  // register write of one byte
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    start_bit();
    send(8'h60);
    send(p);
    send(v);
    stop_bit();
  endtask
  // burst read into rx; last byte answered with a nack
  task automatic rd(input logic [7:0] p, input int n);
    start_bit();
    send(8'h60);
    send(p);
    start_bit();
    send(8'h61);
    for (int i = 0; i < n; i++) xfer(8'hff, i == n - 1, rx[i]);
    stop_bit();
  endtask
  // address byte only, its acknowledge left in ack
  task automatic probe(input logic [7:0] a);
    logic [7:0] q;
    start_bit();
    xfer(a, 1'b1, q);
    stop_bit();
  endtask
endmodule

// ==== rgbt_core_properties.sv ====
/*
  port checker for rgbt_core.
  sees only the core's ports; bound in below.
*/
`timescale 1ns/1ns
module rgbt_core_props #(
  parameter [13:0] BASE_TICK_CYCLES = 14'd12500
) (
  // clock and reset
  input wire       clock,
  input wire       reset,
  // i2c pins
  input wire       scl_pin,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe,
  // sink drive
  input wire [7:0] sink_output_one,
  input wire [7:0] sink_output_two,
  input wire [7:0] sink_output_three
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // the core only ever pulls sda down
  sequence s_oe_on;
    $rose(sda_oe);
  endsequence
  property p_drain;
    sda_out == 1'b0;
  endproperty
  a_drain: assert property (p_drain)
    else $error("sda driven high");
  // drive changes only while scl is low, and holds for three clocks after sda_oe rises
  property p_oe_rise;
    s_oe_on |-> !scl_pin;
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("sda pulled during scl high");
  property p_oe_fall;
    $fell(sda_oe) |-> !scl_pin;
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("sda freed during scl high");
  property p_oe_hold;
    s_oe_on |=> sda_oe [*3];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("sda pull too short");
  // timers restart dark after reset
  property p_quiet;
    $fell(reset) |-> !sda_oe && sink_output_one == 8'h00
      && sink_output_two == 8'h00 && sink_output_three == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("output live after reset");
  // no level above 192 steps
  property p_top_one;
    sink_output_one <= 8'hc0;
  endproperty
  a_top_one: assert property (p_top_one)
    else $error("ch1 level too high");
  property p_top_two;
    sink_output_two <= 8'hc0;
  endproperty
  a_top_two: assert property (p_top_two)
    else $error("ch2 level too high");
  property p_top_three;
    sink_output_three <= 8'hc0;
  endproperty
  a_top_three: assert property (p_top_three)
    else $error("ch3 level too high");
endmodule

bind rgbt_core rgbt_core_props #(
  .BASE_TICK_CYCLES(BASE_TICK_CYCLES)
) chk_u (
  .clock(clock), .reset(reset), .scl_pin(scl_pin), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .sink_output_one(sink_output_one),
  .sink_output_two(sink_output_two),
  .sink_output_three(sink_output_three)
);

// ==== tb_top.sv ====
/*
  self-checking bench for rgbt_core.
  registers reached through the i2c host model; base tick of 4 clocks.
*/
`timescale 1ns/1ns
module tb_top;
  logic       clock;
  logic       reset;
  wire        scl_pin;
  wire        sda_in;
  wire        sda_oe;
  wire [7:0]  s1;
  wire [7:0]  s2;
  wire [7:0]  s3;
  int         fail_count;
  int         checks;
  int         c1;
  int         c2;
  int         c3;
  int         odd;
  int         t0;
  logic [7:0] dflt [0:9] = '{8'h00, 8'h00, 8'h81, 8'h01, 8'h82,
                             8'h00, 8'h3f, 8'h9f, 8'h9f, 8'h00};
  logic [7:0] pat [1:8] = '{8'h85, 8'h5a, 8'ha5, 8'h00,
                            8'hf0, 8'h12, 8'hbf, 8'h01};
  // timer one, timer two, slot code, timer two lit share
  logic [7:0] fl [0:4][0:3] = '{'{8'h80, 8'h40, 8'h00, 8'h40},
    '{8'h60, 8'h40, 8'h01, 8'h40}, '{8'h40, 8'hc0, 8'h02, 8'h80},
    '{8'h60, 8'hc0, 8'h03, 8'h40}, '{8'h00, 8'h40, 8'h00, 8'h40}};

  rgbt_core #(.BASE_TICK_CYCLES(14'd4)) dut_u (
    .clock(clock), .reset(reset), .scl_pin(scl_pin), .sda_in(sda_in),
    .sda_out(), .sda_oe(sda_oe), .sink_output_one(s1),
    .sink_output_two(s2), .sink_output_three(s3));
  rgbt_host_model h (.scl_pin(scl_pin), .sda_in(sda_in), .sda_oe(sda_oe));

  // 50 mhz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // hang guard
  initial begin
    #2000000;
    fail_count++;
    complete_run();
  end

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  function automatic logic near(input int a, input int b);
    return a > b - 13 && a < b + 13;
  endfunction
  // lit cycles per channel; odd counts ch1 levels not 0 or full
  task automatic tally(input int n, input logic [7:0] full);
    odd = 0;
    c1 = 0;
    c2 = 0;
    c3 = 0;
    repeat (n) begin
      cyc(1);
      c1 += (s1 !== 8'h00);
      c2 += (s2 !== 8'h00);
      c3 += (s3 !== 8'h00);
      odd += (s1 !== 8'h00 && s1 !== full);
    end
  endtask
  // bounded wait for ch1 to go lit or dark
  task automatic wait_one(input logic lit);
    int n = 0;
    while (((s1 !== 8'h00) != lit) && n < 12000) begin
      cyc(1);
      n++;
    end
    if (n == 12000) begin
      fail_count++;
      complete_run();
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    fail_count = 0;
    checks = 0;
    cyc(4);
    reset = 1'b0;
    cyc(4);
    // defaults, and one pointer past the map reads zero
    h.rd(8'h00, 10);
    for (int i = 0; i < 10; i++) chk(h.rx[i] === dflt[i], "default");
    h.probe(8'h62);
    chk(h.ack === 1'b1, "foreign address acked");
    $display("test defaults done");
    // readback; channel assignment left at zero
    for (int i = 1; i < 9; i++) h.wr(i[7:0], pat[i]);
    h.rd(8'h01, 8);
    for (int i = 1; i < 9; i++) chk(h.rx[i-1] === pat[i], "readback");
    tally(600, 8'hc0);
    chk(c1 + c2 + c3 == 0, "lit with assignment zero");
    $display("test registers done");
    // slot code kept, no-op cleared, reset command restores defaults
    h.wr(8'h00, 8'h03);
    h.rd(8'h00, 1);
    chk(h.rx[0] === 8'h03, "slot code");
    h.wr(8'h00, 8'h04);
    h.rd(8'h00, 1);
    chk(h.rx[0] === 8'h00, "no-op code");
    h.wr(8'h00, 8'h07);
    h.rd(8'h00, 9);
    for (int i = 0; i < 9; i++) chk(h.rx[i] === dflt[i], "reset cmd");
    $display("test control done");
    // forced on: steady, clamped, lowest step
    h.wr(8'h06, 8'hbf);
    h.wr(8'h07, 8'hc5);
    h.wr(8'h08, 8'h00);
    h.wr(8'h04, 8'h15);
    cyc(50);
    tally(500, 8'hc0);
    chk(c1 == 500 && odd == 0, "ch1 not steady");
    chk(s2 === 8'hc0, "ch2 not clamped");
    chk(s3 === 8'h01, "ch3 lowest step");
    $display("test steady done");
    // slow rise: duty grows, only 0 or full, ends full
    h.wr(8'h04, 8'h00);
    h.wr(8'h05, 8'h08);
    h.wr(8'h04, 8'h01);
    tally(512, 8'hc0);
    t0 = c1;
    chk(odd == 0, "ramp level");
    cyc(1024);
    tally(512, 8'hc0);
    chk(odd == 0 && t0 < c1, "ramp duty");
    cyc(600);
    chk(s1 === 8'hc0, "ramp end");
    // slowest rise, level near 64: linear duty about twice the s-curve
    h.wr(8'h04, 8'h00);
    h.wr(8'h05, 8'h0f);
    h.wr(8'h01, 8'h80);
    h.wr(8'h04, 8'h01);
    cyc(4096);
    tally(512, 8'hc0);
    t0 = c1;
    h.wr(8'h04, 8'h00);
    h.wr(8'h01, 8'h00);
    h.wr(8'h04, 8'h01);
    cyc(4096);
    tally(512, 8'hc0);
    chk(odd == 0 && t0 > c1 + 32, "ramp profile");
    $display("test ramp done");
    // ch1 on timer one, ch2 on timer two, each slot code
    h.wr(8'h05, 8'h00);
    h.wr(8'h04, 8'h0e);
    for (int k = 0; k < 5; k++) begin
      h.wr(8'h02, fl[k][0]);
      h.wr(8'h03, fl[k][1]);
      h.wr(8'h00, fl[k][2]);
      cyc(1024);
      tally(2048, 8'hc0);
      chk(near(c1, 8 * int'(fl[k][0])), "timer one");
      chk(near(c2, 8 * int'(fl[k][3])), "timer two");
      chk(c3 == 0, "ch3 lit");
    end
    $display("test flash done");
    // period at setting 1: (1 + 4) * 256 ticks of 4 clocks
    h.wr(8'h02, 8'h80);
    h.wr(8'h01, 8'h01);
    wait_one(1'b0);
    wait_one(1'b1);
    t0 = int'($time);
    wait_one(1'b0);
    wait_one(1'b1);
    chk(near((int'($time) - t0) / 20, 5120), "period");
    chk(h.nacks == 0, "byte not acked");
    $display("test period done");
    complete_run();
  end
endmodule
